// ---- verilog/pdl_map.vh ----
/*
 * Register indices, field positions, reset values and timing counts of the
 * duty-limited PWM regulation core.
 * Assumes it is included by bare name and holds definitions only.
 */
`ifndef PDL_MAP_VH
`define PDL_MAP_VH

// Register indices on the configuration port
`define PDL_REG_LIMIT    4'h0
`define PDL_REG_C0_UPPER 4'h1
`define PDL_REG_C0_LOWER 4'h2
`define PDL_REG_C1_UPPER 4'h3
`define PDL_REG_C1_LOWER 4'h4
`define PDL_REG_C2_UPPER 4'h5
`define PDL_REG_C2_LOWER 4'h6
`define PDL_REG_C3_UPPER 4'h7
`define PDL_REG_C3_LOWER 4'h8
`define PDL_REG_B1       4'h9
`define PDL_REG_B2       4'ha
`define PDL_REG_B3       4'hb
`define PDL_REG_STATUS   4'hc

// Fields of the limit register
`define PDL_LIMIT_MSB    7
`define PDL_LIMIT_LSB    2
`define PDL_CEIL_EN_BIT  1
`define PDL_FLOOR_EN_BIT 0
`define PDL_LIMIT_RST    8'he8

// Coefficient reset value
`define PDL_COEF_RST     8'h00

// One switching period in ticks: duty steps of 1/192
`define PDL_PERIOD       8'hc0
// Saturation window half width in error codes
`define PDL_WINDOW       8'h40
// Filter output scaling shift
`define PDL_SHIFT        8

`endif

// ---- verilog/pdl_share.v ----
/*
 * Digital current-share line unit: drives the shared open-drain line low
 * for as many ticks as this converter's current code and measures how long
 * the wired line stays low, which is the largest current on the line.
 * Assumes the share line comes from outside the clock domain.
 */
`timescale 1ns/1ps

module pdl_share #(
	parameter W = 8
) (
	clk,
	rst_n,
	ce,
	periodStart,
	tickCnt,
	curCode,
	shareIn,
	shareOe,
	maxCur
);
	input  wire         clk;
	input  wire         rst_n;
	input  wire         ce;
	input  wire         periodStart;
	input  wire [W-1:0] tickCnt;
	input  wire [W-1:0] curCode;
	input  wire         shareIn;
	output reg          shareOe;
	output reg  [W-1:0] maxCur;

	reg         syncA_r;
	reg         syncB_r;
	reg [W-1:0] lowCnt_r;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser; only syncB_r is looked at
	always @(posedge clk) begin
		if (!rst_n) begin
			syncA_r <= 1'b1;
			syncB_r <= 1'b1;
		end else if (ce) begin
			syncA_r <= shareIn;
			syncB_r <= syncA_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pull the line low while within our own current, count line low time
	always @(posedge clk) begin
		if (!rst_n) begin
			shareOe  <= 1'b0;
			lowCnt_r <= {W{1'b0}};
			maxCur   <= {W{1'b0}};
		end else if (ce) begin
			shareOe <= (tickCnt < curCode);
			if (periodStart) begin
				maxCur   <= lowCnt_r; // Largest current seen last period
				lowCnt_r <= {W{1'b0}};
			end else if (!syncB_r) begin
				lowCnt_r <= lowCnt_r + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // pdl_share

// ---- verilog/pdl_core.v ----
/*
 * Duty-limited PWM regulation core: limit and saturation register, third
 * order compensation filter with programmable coefficients, saturation
 * feed-forward, duty clamp and digital current share.
 * Assumes the serial front end delivers register writes on the same clock,
 * the error code comes from same-clock ADC logic, and the share line is
 * an external open-drain wire (pull low when shareOe is high).
 */
// Operation
// - Duty capped at six-bit field over 192
// - Bit1 enables ceiling, bit0 floor feed-forward
// - Large transient forces duty zero or limit
// - Outside window, reach limit within one period
// - Inside window, duty follows filter proportionally
// - Third-order filter: integrator, two zeros, lowpass
// - Four numerator, three denominator programmable coefficients
// - Numerators as byte pairs, denominators single
// - Share line equalises paralleled converter currents
// - Configuration writes accepted only while off
`timescale 1ns/1ps
`include "pdl_map.vh"

module pdl_core (
	clk,
	rst_n,
	ce,
	convOn,
	regWe,
	regAddr,
	regWrData,
	errCode,
	curCode,
	shareIn,
	pwmOut,
	shareOut,
	shareOe,
	rdData,
	satActive
);
	input  wire       clk;
	input  wire       rst_n;
	input  wire       ce;
	input  wire       convOn;
	input  wire       regWe;
	input  wire [3:0] regAddr;
	input  wire [7:0] regWrData;
	input  wire [7:0] errCode;   // Signed error, positive means output low
	input  wire [7:0] curCode;   // Own output current in share ticks
	input  wire       shareIn;
	output reg        pwmOut;
	output reg        shareOut;
	output wire       shareOe;
	output reg  [7:0] rdData;
	output reg        satActive;

	localparam ST_IDLE = 2'b00;
	localparam ST_MAC  = 2'b01;
	localparam ST_DONE = 2'b10;

	reg  [7:0]         limit_r;
	reg  [7:0]         coefUp_r [0:3];
	reg  [7:0]         coefLo_r [0:3];
	reg  [7:0]         den_r    [1:3];
	reg  [7:0]         tick_r;
	reg  [7:0]         dutyNext_r;
	reg  [7:0]         dutyAct_r;
	reg  [1:0]         state_r;
	reg  [2:0]         step_r;
	reg  signed [39:0] acc_r;
	reg  signed [15:0] e0_r, e1_r, e2_r, e3_r;
	reg  signed [15:0] u1_r, u2_r, u3_r;
	reg                satHi_r, satLo_r;
	reg  signed [15:0] coefSel, sampSel;
	reg                subSel;
	reg  signed [15:0] uNew;
	reg  [7:0]         dutyFilt;
	reg  signed [9:0]  effErr;
	wire [7:0]         maxCur, limitTicks;
	wire signed [31:0] prod;
	wire signed [39:0] accShift;
	wire               periodStart;
	integer            i;

	assign limitTicks  = {2'b00, limit_r[`PDL_LIMIT_MSB:`PDL_LIMIT_LSB]};
	assign periodStart = (tick_r == 8'h00);
	assign prod        = coefSel * sampSel;
	assign accShift    = acc_r >>> `PDL_SHIFT;

	////////////////////////////////////////////////////////////////////////
	// Current share unit on the shared line
	pdl_share #(
		.W (8)
	) u_share (
		.clk         (clk),
		.rst_n       (rst_n),
		.ce          (ce),
		.periodStart (periodStart),
		.tickCnt     (tick_r),
		.curCode     (curCode),
		.shareIn     (shareIn),
		.shareOe     (shareOe),
		.maxCur      (maxCur)
	);

	////////////////////////////////////////////////////////////////////////
	// Configuration registers; a running converter ignores writes because
	// retuning the loop mid-regulation could upset the output
	always @(posedge clk) begin
		if (!rst_n) begin
			limit_r <= `PDL_LIMIT_RST;
			for (i = 0; i < 4; i = i + 1) begin
				coefUp_r[i] <= `PDL_COEF_RST;
				coefLo_r[i] <= `PDL_COEF_RST;
			end
			for (i = 1; i < 4; i = i + 1) begin
				den_r[i] <= `PDL_COEF_RST;
			end
		end else if (ce && regWe && !convOn) begin
			case (regAddr)
			`PDL_REG_LIMIT:    limit_r     <= regWrData;
			`PDL_REG_C0_UPPER: coefUp_r[0] <= regWrData;
			`PDL_REG_C0_LOWER: coefLo_r[0] <= regWrData;
			`PDL_REG_C1_UPPER: coefUp_r[1] <= regWrData;
			`PDL_REG_C1_LOWER: coefLo_r[1] <= regWrData;
			`PDL_REG_C2_UPPER: coefUp_r[2] <= regWrData;
			`PDL_REG_C2_LOWER: coefLo_r[2] <= regWrData;
			`PDL_REG_C3_UPPER: coefUp_r[3] <= regWrData;
			`PDL_REG_C3_LOWER: coefLo_r[3] <= regWrData;
			`PDL_REG_B1:       den_r[1]    <= regWrData;
			`PDL_REG_B2:       den_r[2]    <= regWrData;
			`PDL_REG_B3:       den_r[3]    <= regWrData;
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered read-back; status shows the duty in force (dutyAct_r), saturated duty included
	always @(posedge clk) begin
		if (!rst_n) begin
			rdData <= 8'h00;
		end else if (ce) begin
			case (regAddr)
			`PDL_REG_LIMIT:    rdData <= limit_r;
			`PDL_REG_C0_UPPER: rdData <= coefUp_r[0];
			`PDL_REG_C0_LOWER: rdData <= coefLo_r[0];
			`PDL_REG_C1_UPPER: rdData <= coefUp_r[1];
			`PDL_REG_C1_LOWER: rdData <= coefLo_r[1];
			`PDL_REG_C2_UPPER: rdData <= coefUp_r[2];
			`PDL_REG_C2_LOWER: rdData <= coefLo_r[2];
			`PDL_REG_C3_UPPER: rdData <= coefUp_r[3];
			`PDL_REG_C3_LOWER: rdData <= coefLo_r[3];
			`PDL_REG_B1:       rdData <= den_r[1];
			`PDL_REG_B2:       rdData <= den_r[2];
			`PDL_REG_B3:       rdData <= den_r[3];
			`PDL_REG_STATUS:   rdData <= dutyAct_r;
			default:           rdData <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tap selection for the shared multiplier: numerators add, the
	// denominators subtract (one multiplier traded for seven clock steps)
	always @* begin
		subSel = step_r[2];
		case (step_r)
		3'h4:    coefSel = {{8{den_r[1][7]}}, den_r[1]};
		3'h5:    coefSel = {{8{den_r[2][7]}}, den_r[2]};
		3'h6:    coefSel = {{8{den_r[3][7]}}, den_r[3]};
		default: coefSel = {coefUp_r[step_r[1:0]], coefLo_r[step_r[1:0]]};
		endcase
		case (step_r)
		3'h0:    sampSel = e0_r;
		3'h1:    sampSel = e1_r;
		3'h2:    sampSel = e2_r;
		3'h3:    sampSel = e3_r;
		3'h4:    sampSel = u1_r;
		3'h5:    sampSel = u2_r;
		3'h6:    sampSel = u3_r;
		default: sampSel = 16'sh0000; // Step 7 is never accumulated
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Filter output saturation to 16 bits, then clamp to [0, limit]
	always @* begin
		if (accShift > 40'sh0000007fff) begin
			uNew = 16'sh7fff;
		end else if (accShift < -40'sh0000008000) begin
			uNew = -16'sh8000;
		end else begin
			uNew = accShift[15:0];
		end
		if (uNew[15]) begin
			dutyFilt = 8'h00;
		end else if (uNew > {8'h00, limitTicks}) begin
			dutyFilt = limitTicks;
		end else begin
			dutyFilt = uNew[7:0]; // Proportional path inside window
		end
		// Share correction: a converter below the line maximum pushes up
		effErr = {{2{errCode[7]}}, errCode} + {2'b00, maxCur} - {2'b00, curCode};
	end

	////////////////////////////////////////////////////////////////////////
	// Switching period counter and PWM output; new duty takes hold only at
	// a period boundary so no pulse is cut short or stretched
	always @(posedge clk) begin
		if (!rst_n) begin
			tick_r    <= 8'h00;
			dutyAct_r <= 8'h00;
			pwmOut    <= 1'b0;
			shareOut  <= 1'b0;
		end else if (ce) begin
			tick_r <= (tick_r == `PDL_PERIOD - 8'h01) ? 8'h00 : tick_r + 8'h01;
			if (periodStart) begin
				dutyAct_r <= dutyNext_r;
				pwmOut    <= (dutyNext_r != 8'h00);
			end else begin
				pwmOut <= (tick_r < dutyAct_r);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-period compensation: sample, seven MAC steps, decide duty
	always @(posedge clk) begin
		if (!rst_n) begin
			state_r    <= ST_IDLE;
			step_r     <= 3'h0;
			acc_r      <= 40'sh0;
			e0_r       <= 16'sh0;
			e1_r       <= 16'sh0;
			e2_r       <= 16'sh0;
			e3_r       <= 16'sh0;
			u1_r       <= 16'sh0;
			u2_r       <= 16'sh0;
			u3_r       <= 16'sh0;
			satHi_r    <= 1'b0;
			satLo_r    <= 1'b0;
			satActive  <= 1'b0;
			dutyNext_r <= 8'h00;
		end else if (ce) begin
			case (state_r)
			ST_IDLE: begin
				if (periodStart) begin
					e0_r    <= {{6{effErr[9]}}, effErr};
					// Window comparators on the error
					satHi_r <= limit_r[`PDL_CEIL_EN_BIT] &&
					           (effErr >= $signed({2'b00, `PDL_WINDOW}));
					satLo_r <= limit_r[`PDL_FLOOR_EN_BIT] &&
					           (effErr <= -$signed({2'b00, `PDL_WINDOW}));
					acc_r   <= 40'sh0;
					step_r  <= 3'h0;
					state_r <= ST_MAC;
				end
			end
			ST_MAC: begin
				// Sum of four numerator and three denominator taps
				acc_r  <= subSel ? acc_r - prod : acc_r + prod;
				step_r <= step_r + 3'h1;
				if (step_r == 3'h6) begin
					state_r <= ST_DONE;
				end
			end
			ST_DONE: begin
				// Shift histories; recursion on u gives integrator and lowpass
				e1_r <= e0_r;
				e2_r <= e1_r;
				e3_r <= e2_r;
				u1_r <= uNew;
				u2_r <= u1_r;
				u3_r <= u2_r;
				if (satHi_r) begin
					dutyNext_r <= limitTicks; // Straight to the limit
				end else if (satLo_r) begin
					dutyNext_r <= 8'h00; // Straight to zero
				end else begin
					dutyNext_r <= dutyFilt;
				end
				satActive <= satHi_r | satLo_r;
				state_r   <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // pdl_core

// ---- tb/pdl_core_assertions.sv ----
/* Port checker for the regulation core.
   Assumes one clock, synchronous reset that the core takes regardless of ce, and a limit register
   that only changes through accepted writes. */
`timescale 1ns/1ps
module pdl_core_chk (
	input wire       clk,
	input wire       rst_n,
	input wire       ce,
	input wire       convOn,
	input wire       regWe,
	input wire [3:0] regAddr,
	input wire [7:0] regWrData,
	input wire [7:0] errCode,
	input wire [7:0] curCode,
	input wire       shareIn,
	input wire       pwmOut,
	input wire       shareOut,
	input wire       shareOe,
	input wire [7:0] rdData,
	input wire       satActive
);
	reg [7:0] highRun, lowRun, limR, sinceWr;
	wire      wrLim = regWe && !convOn && regAddr == 4'h0;

	// Shadow limit and pulse run counters; frozen with ce like the core
	always @(posedge clk) begin
		if (ce) begin
			if (!rst_n) begin
				highRun <= 8'h00;
				lowRun  <= 8'hff;
				limR    <= 8'he8;
				sinceWr <= 8'h00;
			end else begin
				highRun <= pwmOut ? highRun + 8'h01 : 8'h00;
				lowRun  <= (pwmOut) ? 8'h00 : (!convOn || lowRun == 8'hff) ? 8'hff : lowRun + 8'h01;
				limR    <= wrLim ? regWrData : limR;
				sinceWr <= wrLim ? 8'h00 : (sinceWr == 8'hff) ? 8'hff : sinceWr + 8'h01;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_reset_vals: assert property (disable iff (1'b0) (!rst_n && ce) |=>
		(!pwmOut && !shareOe && rdData == 8'h00 && !satActive)) else $error("reset values");
	a_share_idle: assert property (shareOut == 1'b0) else $error("share out driven");
	a_unmapped_read: assert property ((ce && regAddr > 4'hc) |=> rdData == 8'h00)
		else $error("unmapped read");
	a_limit_shadow: assert property ((ce && regAddr == 4'h0) |=> rdData == $past(limR))
		else $error("limit readback");
	a_write_refused: assert property ((ce && regAddr == 4'h0 && !wrLim) ##1
		(ce && regAddr == 4'h0) |=> $stable(rdData)) else $error("write taken");
	a_pwm_high_cap: assert property (highRun <= 8'd63) else $error("pulse too long");
	a_pwm_low_gap: assert property ($rose(pwmOut) |-> lowRun >= 8'd129)
		else $error("period too short");
	a_share_with_pwm: assert property (($rose(pwmOut) && $stable(curCode) &&
		curCode != 8'h00) |-> shareOe) else $error("share not driven");
	a_sat_needs_en: assert property ((satActive && sinceWr == 8'hff) |->
		limR[1:0] != 2'b00) else $error("saturation while disabled");
endmodule // pdl_core_chk
////////////////////////////////////////////////////////////////
bind pdl_core pdl_core_chk u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .convOn(convOn),
	.regWe(regWe), .regAddr(regAddr), .regWrData(regWrData), .errCode(errCode),
	.curCode(curCode), .shareIn(shareIn), .pwmOut(pwmOut), .shareOut(shareOut),
	.shareOe(shareOe), .rdData(rdData), .satActive(satActive));

// ---- tb/pdl_share_peer.sv ----
/* Paralleled converter on the share line.
   Assumes the same switching period as the core and a pulled-up line. */
`timescale 1ns/1ps
module pdl_share_peer (
	input wire       clk,
	input wire       rst_n,
	input wire       ce,
	input wire [7:0] peerCur,
	output reg       peerOe
);
	reg [7:0] tick_r;

	// Identical period; its differing current plays one unit's load regulation
	always @(posedge clk) begin
		if (!rst_n) begin
			tick_r <= 8'h00;
			peerOe <= 1'b0;
		end else if (ce) begin
			tick_r <= (tick_r == 8'hbf) ? 8'h00 : tick_r + 8'h01;
			peerOe <= tick_r < peerCur;
		end
	end
endmodule // pdl_share_peer

// ---- tb/pwm_duty_limit_compensator_tb.sv ----
/* Self-checking bench of the regulation core.
   Assumes a pulled-up share line joined to one peer converter. */
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module pwm_duty_limit_compensator_tb;
	reg        clk, rst_n, ce, convOn, regWe;
	reg  [3:0] regAddr;
	reg  [7:0] regWrData, errCode, curCode, peerCur, d, q, h, s, lim, e;
	reg [15:0] c0;
	reg [31:0] v, cs[0:4];
	wire       pwmOut, shareOut, shareOe, satActive, peerOe;
	wire [7:0] rdData;
	wire       shareIn = !(shareOe || peerOe); // Pull-up when released
	integer    err_total, checks_done, seed, i;

	pdl_core u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .convOn(convOn), .regWe(regWe),
		.regAddr(regAddr), .regWrData(regWrData), .errCode(errCode), .curCode(curCode),
		.shareIn(shareIn), .pwmOut(pwmOut), .shareOut(shareOut), .shareOe(shareOe),
		.rdData(rdData), .satActive(satActive));
	pdl_share_peer u_peer (.clk(clk), .rst_n(rst_n), .ce(ce), .peerCur(peerCur),
		.peerOe(peerOe));

	////////////////////////////////////////////////////////////////
	task wr(input [3:0] a, input [7:0] x); begin
		@(posedge clk) begin regWe <= 1'b1; regAddr <= a; regWrData <= x; end
		@(posedge clk) regWe <= 1'b0;
	end endtask
	task rd(input [3:0] a, output [7:0] x); begin
		@(posedge clk) regAddr <= a;
		@(posedge clk) #1 x = rdData;
	end endtask
	// Writes are refused while on, so the converter is stopped first
	// No output setpoint is modelled, so limit and saturation picks are free
	task cfg(input [7:0] l, input [7:0] x, input [15:0] c); begin
		@(posedge clk) begin convOn <= 1'b0; errCode <= x; end
		wr(4'h0, l); wr(4'h1, c[15:8]); wr(4'h2, c[7:0]);
		@(posedge clk) convOn <= 1'b1;
	end endtask
	// Settling of two periods and a margin, then one period counted
	task meas(output [7:0] hc, output [7:0] sc); integer k; begin
		hc = 8'h00; sc = 8'h00;
		repeat (400) @(posedge clk);
		for (k = 0; k < 192; k++) begin @(posedge clk) #1 hc += pwmOut; sc += shareOe; end
	end endtask
	function [7:0] expd(input [7:0] l, input [7:0] x, input [15:0] c); integer u; begin
		u = ($signed(c) * $signed(x)) >>> 8;
		if ($signed(x) >= 64 && l[1]) u = l[7:2];
		else if ($signed(x) <= -64 && l[0]) u = 0;
		else if (u < 0) u = 0;
		else if (u > l[7:2]) u = l[7:2];
		expd = u[7:0];
	end endfunction
	task stop_test; begin
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	end endtask

	////////////////////////////////////////////////////////////////
	initial begin clk = 1'b0; forever #50 clk = ~clk; end
	initial begin #5000000 err_total++; stop_test; end
	initial begin
		seed = 32'hcdf76831; err_total = 0; checks_done = 0; rst_n = 1'b0; ce = 1'b1;
		convOn = 1'b0; regWe = 1'b0; regAddr = 4'h0; regWrData = 8'h00; errCode = 8'h00;
		curCode = 8'd30; peerCur = 8'd10;
		cs[0] = 32'h02500100; cs[1] = 32'hfe50ff00; cs[2] = 32'hfdb0ff00;
		cs[3] = 32'hfc50ff00; cs[4] = 32'he8140100;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(4'h0, d); `CHK(d, 8'he8)
		for (i = 1; i < 16; i++) begin
			if (i > 11) wr(i[3:0], 8'h5a);
			rd(i[3:0], d); `CHK(d, 8'h00)
		end
		for (i = 1; i < 12; i++) begin
			d = $random(seed); wr(i[3:0], d);
			@(posedge clk) convOn <= 1'b1;
			wr(i[3:0], ~d);
			@(posedge clk) convOn <= 1'b0;
			rd(i[3:0], q); `CHK(q, d)
		end
		for (i = 1; i < 12; i++) wr(i[3:0], 8'h00);
		for (i = 0; i < 12; i++) begin
			v = (i < 5) ? cs[i] : $random(seed);
			lim = v[31:24]; e = v[23:16];
			c0 = (i < 5) ? v[15:0] : v[0] ? 16'hff00 : v[1] ? 16'h7fff : 16'h0100;
			cfg(lim, e, c0); meas(h, s);
			`CHK(h, expd(lim, e, c0))
			`CHK(satActive, ($signed(e) >= 64 && lim[1]) || ($signed(e) <= -64 && lim[0]))
			`CHK(s, curCode)
			rd(4'hc, q); `CHK(q, expd(lim, e, c0))
		end
		// Peer above our own current: share correction lifts the error to 25;
		// the new line maximum needs up to four periods to reach the pulse
		@(posedge clk) peerCur <= 8'd50;
		cfg(8'hfc, 8'h05, 16'h0100); meas(h, s); meas(h, s);
		`CHK(h, 8'd25)
		// Denominator tap of -64 feeds back a quarter of u: 25/(3/4) truncates to 33
		@(posedge clk) convOn <= 1'b0;
		wr(4'h9, 8'hc0);
		cfg(8'hfc, 8'h05, 16'h0100); meas(h, s); meas(h, s);
		`CHK(h, 8'd33)
		// Clock enable low inside a pulse: a running core would end it within 33
		@(posedge pwmOut);
		@(posedge clk) ce <= 1'b0;
		@(posedge clk) #1 d = {pwmOut, shareOe, satActive, 5'h00};
		q = rdData;
		repeat (40) @(posedge clk);
		#1 `CHK({pwmOut, shareOe, satActive, 5'h00}, d)
		`CHK(rdData, q)
		@(posedge clk) ce <= 1'b1;
		meas(h, s); `CHK(h, 8'd33)
		stop_test;
	end
endmodule // pwm_duty_limit_compensator_tb
